// *** src/irqp_params.svh ***
/*
 * Constants of the interrupt enable and priority block: register
 * indices, reset values, write masks, field positions, source slots.
 * Assumes inclusion by the package, the top module and the testbench.
 */
`ifndef IRQP_PARAMS_SVH
`define IRQP_PARAMS_SVH

// Register indices; the byte address is four times the index
`define IRQP_IDX_BASE_PRIO 8'hb8
`define IRQP_IDX_EXT_EN 8'hf6
`define IRQP_IDX_EXT_PRIO 8'hf7
`define IRQP_IDX_CTRL 8'hf8
`define IRQP_IDX_STATUS 8'hf9

// Reset values
`define IRQP_RST_BASE_PRIO 8'h80
`define IRQP_RST_EXT_EN 8'h00
`define IRQP_RST_EXT_PRIO 8'h00
`define IRQP_RST_CTRL 8'h00

// Writable bits and bits that read as one
`define IRQP_WMASK_BASE_PRIO 8'h7f
`define IRQP_ONES_BASE_PRIO 8'h80
`define IRQP_WMASK_EXT 8'hbd

// Fields of the extended enable and priority registers
`define IRQP_EXT_T3 7
`define IRQP_EXT_CMP 5
`define IRQP_EXT_PCA 4
`define IRQP_EXT_CONV 3
`define IRQP_EXT_WCMP 2
`define IRQP_EXT_SMB 0

// Control register: global enable and basic enables 6..0
`define IRQP_CTRL_GIE 7
`define IRQP_BASE_BITS 7

// Source slots, lowest slot wins within a level
`define IRQP_NSRC 15
`define IRQP_SRC_SMB 7
`define IRQP_SRC_WCMP 9
`define IRQP_SRC_CONV 10
`define IRQP_SRC_PCA 11
`define IRQP_SRC_CMP 12
`define IRQP_SRC_T3 14

`endif

// *** src/irqp_pkg.sv ***
/*
 * Types of the interrupt enable and priority block.
 * Assumes irqp_params.svh on the include path.
 */
`include "irqp_params.svh"

package irqp_pkg;

	typedef logic [`IRQP_NSRC-1:0] irqp_src_t;

	// Request to the CPU core
	typedef struct packed {
		logic req;
		logic high;
		logic [3:0] vec;
	} irqp_req_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_HOLD = 2'b01
	} irqp_hold_t;

	typedef enum logic [2:0] {
		REG_NONE,
		REG_BASE_PRIO,
		REG_EXT_EN,
		REG_EXT_PRIO,
		REG_CTRL,
		REG_STATUS
	} irqp_reg_t;

endpackage

// *** src/irqp_top.sv ***
/*
 * Interrupt enable and priority registers with request selection,
 * reached over an AHB-Lite slave port.
 * Assumes peripheral flags and CPU strobes are synchronous to clk.
 */
// The AHB-Lite register port was left to the implementer.
// Operation
// - Basic priority bit 7 reads one; writes to it are ignored.
// - Basic priority bit 6 sets SPI interrupt level.
// - Basic priority bit 5 sets timer 2 interrupt level.
// - Basic priority bit 4 sets serial port interrupt level.
// - Basic priority bit 3 sets timer 1 interrupt level.
// - Basic priority bit 2 sets external input 1 level.
// - Basic priority bit 1 sets timer 0 interrupt level.
// - Basic priority bit 0 sets external input 0 level.
// - Extended enable bit 7 gates both timer 3 overflow flags.
// - Extended enable bits 6 and 1 read zero; software writes zero.
// - Extended enable bit 5 gates both comparator edge flags.
// - Extended enable bit 4 gates all counter array requests.
// - Extended enable bit 3 gates conversion complete request.
// - Extended enable bit 2 gates window compare request.
// - Extended enable bit 0 gates all SMBus requests.
// - Extended priority bit 3 sets conversion complete level.
// - Extended priority bit 2 sets window compare level.
// - Extended priority bit 1 reads zero; software writes zero.
// - Extended priority bit 0 sets SMBus interrupt level.
// - Global enable off blocks all sources; on follows each enable.
// - Pending requests sampled and priority decoded every cycle.
// - Equal or higher service, or return plus one instruction, holds.
`timescale 1ns/100ps
`include "irqp_params.svh"

module irqp_top import irqp_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Peripheral interrupt flags
	input wire logic ext0_flag,
	input wire logic timer0_flag,
	input wire logic ext1_flag,
	input wire logic timer1_flag,
	input wire logic serial_port_flag,
	input wire logic timer2_flag,
	input wire logic spi_flag,
	input wire logic smbus_flag,
	input wire logic window_compare_flag,
	input wire logic conversion_complete_flag,
	input wire logic counter_array_flag,
	input wire logic comparator_rising_flag,
	input wire logic comparator_falling_flag,
	input wire logic timer3_low_overflow_flag,
	input wire logic timer3_high_overflow_flag,
	// CPU core
	input wire logic cpu_irq_ack,
	input wire logic cpu_reti,
	input wire logic cpu_instr_done,
	output irqp_req_t cpu_irq
);

	if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_chk
		$error("irqp_top: ADDR_W must lie in 10..32");
	end

	function automatic irqp_reg_t reg_decode(logic [ADDR_W-1:0] a);
		irqp_reg_t r;
		r = REG_NONE;
		if (a[1:0] == 2'b00 && (a >> 10) == '0) begin
			case (a[9:2])
				`IRQP_IDX_BASE_PRIO: r = REG_BASE_PRIO;
				`IRQP_IDX_EXT_EN: r = REG_EXT_EN;
				`IRQP_IDX_EXT_PRIO: r = REG_EXT_PRIO;
				`IRQP_IDX_CTRL: r = REG_CTRL;
				`IRQP_IDX_STATUS: r = REG_STATUS;
				default: r = REG_NONE;
			endcase
		end
		return r;
	endfunction

	// Lowest set slot of a request vector
	function automatic logic [3:0] first_set(irqp_src_t v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = `IRQP_NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	// Bus phase state
	logic ahb_go;
	irqp_reg_t sel_a;
	irqp_reg_t wsel_reg, wsel_next;
	logic [31:0] hrdata_reg, hrdata_next;

	// Software registers
	logic [7:0] base_irq_priority_reg, base_irq_priority_next;
	logic [7:0] ext_irq_enable_1_reg, ext_irq_enable_1_next;
	logic [7:0] ext_irq_priority_1_reg, ext_irq_priority_1_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] status_rd;

	// Interrupt state
	irqp_src_t src_raw, en_vec, prio_vec, hi_vec, lo_vec;
	irqp_src_t pend_reg, pend_next;
	logic isr_hi_reg, isr_hi_next;
	logic isr_lo_reg, isr_lo_next;
	irqp_hold_t hold_reg, hold_next;
	irqp_req_t req_reg, req_next;
	logic can_hi, can_lo, global_irq_enable;

	assign ahb_go = hsel && htrans[1] && hready;
	assign sel_a = reg_decode(haddr);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign cpu_irq = req_reg;
	assign global_irq_enable = ctrl_reg[`IRQP_CTRL_GIE];

	// Bus address phase and registers written in the data phase
	always_comb begin
		wsel_next = (ahb_go && hwrite) ? sel_a : REG_NONE;
		base_irq_priority_next = base_irq_priority_reg;
		ext_irq_enable_1_next = ext_irq_enable_1_reg;
		ext_irq_priority_1_next = ext_irq_priority_1_reg;
		ctrl_next = ctrl_reg;
		unique case (wsel_reg)
			REG_BASE_PRIO: begin
				base_irq_priority_next = `IRQP_ONES_BASE_PRIO |
					(hwdata[7:0] & `IRQP_WMASK_BASE_PRIO);
			end
			REG_EXT_EN: begin
				ext_irq_enable_1_next = hwdata[7:0] &
					`IRQP_WMASK_EXT;
			end
			REG_EXT_PRIO: begin
				ext_irq_priority_1_next = hwdata[7:0] &
					`IRQP_WMASK_EXT;
			end
			REG_CTRL: begin
				ctrl_next = hwdata[7:0];
			end
			REG_STATUS, REG_NONE: begin
			end
		endcase
	end

	// Read data taken from the next values so a write just ahead shows
	always_comb begin
		status_rd = {isr_hi_reg, isr_lo_reg, hold_reg == ST_HOLD,
			req_reg.req, req_reg.vec};
		hrdata_next = 32'h0000_0000;
		if (ahb_go && !hwrite) begin
			unique case (sel_a)
				REG_BASE_PRIO: hrdata_next[7:0] = base_irq_priority_next;
				REG_EXT_EN: hrdata_next[7:0] = ext_irq_enable_1_next;
				REG_EXT_PRIO: hrdata_next[7:0] = ext_irq_priority_1_next;
				REG_CTRL: hrdata_next[7:0] = ctrl_next;
				REG_STATUS: hrdata_next[7:0] = status_rd;
				REG_NONE: hrdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wsel_reg <= REG_NONE;
			hrdata_reg <= 32'h0000_0000;
			base_irq_priority_reg <= `IRQP_RST_BASE_PRIO;
			ext_irq_enable_1_reg <= `IRQP_RST_EXT_EN;
			ext_irq_priority_1_reg <= `IRQP_RST_EXT_PRIO;
			ctrl_reg <= `IRQP_RST_CTRL;
		end else begin
			wsel_reg <= wsel_next;
			hrdata_reg <= hrdata_next;
			base_irq_priority_reg <= base_irq_priority_next;
			ext_irq_enable_1_reg <= ext_irq_enable_1_next;
			ext_irq_priority_1_reg <= ext_irq_priority_1_next;
			ctrl_reg <= ctrl_next;
		end
	end

	// Source, enable and level vectors by slot
	always_comb begin
		src_raw = '0;
		en_vec = '0;
		prio_vec = '0;
		src_raw[`IRQP_BASE_BITS-1:0] = {spi_flag, timer2_flag,
			serial_port_flag, timer1_flag, ext1_flag, timer0_flag,
			ext0_flag};
		src_raw[`IRQP_SRC_SMB] = smbus_flag;
		src_raw[`IRQP_SRC_WCMP] = window_compare_flag;
		src_raw[`IRQP_SRC_CONV] = conversion_complete_flag;
		src_raw[`IRQP_SRC_PCA] = counter_array_flag;
		src_raw[`IRQP_SRC_CMP] = comparator_rising_flag |
			comparator_falling_flag;
		src_raw[`IRQP_SRC_T3] = timer3_low_overflow_flag |
			timer3_high_overflow_flag;
		en_vec[`IRQP_BASE_BITS-1:0] = ctrl_reg[`IRQP_BASE_BITS-1:0];
		en_vec[`IRQP_SRC_SMB] = ext_irq_enable_1_reg[`IRQP_EXT_SMB];
		en_vec[`IRQP_SRC_WCMP] =
			ext_irq_enable_1_reg[`IRQP_EXT_WCMP];
		en_vec[`IRQP_SRC_CONV] =
			ext_irq_enable_1_reg[`IRQP_EXT_CONV];
		en_vec[`IRQP_SRC_PCA] = ext_irq_enable_1_reg[`IRQP_EXT_PCA];
		en_vec[`IRQP_SRC_CMP] = ext_irq_enable_1_reg[`IRQP_EXT_CMP];
		en_vec[`IRQP_SRC_T3] = ext_irq_enable_1_reg[`IRQP_EXT_T3];
		if (!global_irq_enable) begin
			en_vec = '0;
		end
		// Basic levels, bit n to slot n
		prio_vec[`IRQP_BASE_BITS-1:0] =
			base_irq_priority_reg[`IRQP_BASE_BITS-1:0];
		prio_vec[`IRQP_SRC_SMB] =
			ext_irq_priority_1_reg[`IRQP_EXT_SMB];
		prio_vec[`IRQP_SRC_WCMP] =
			ext_irq_priority_1_reg[`IRQP_EXT_WCMP];
		prio_vec[`IRQP_SRC_CONV] =
			ext_irq_priority_1_reg[`IRQP_EXT_CONV];
		prio_vec[`IRQP_SRC_PCA] =
			ext_irq_priority_1_reg[`IRQP_EXT_PCA];
		prio_vec[`IRQP_SRC_CMP] =
			ext_irq_priority_1_reg[`IRQP_EXT_CMP];
		prio_vec[`IRQP_SRC_T3] =
			ext_irq_priority_1_reg[`IRQP_EXT_T3];
	end

	// Sampling, decode, service tracking and hold after return
	always_comb begin
		pend_next = src_raw & en_vec;
		hi_vec = pend_reg & prio_vec;
		lo_vec = pend_reg & ~prio_vec;
		isr_hi_next = isr_hi_reg;
		isr_lo_next = isr_lo_reg;
		hold_next = hold_reg;
		if (cpu_irq_ack && req_reg.req) begin
			if (req_reg.high) begin
				isr_hi_next = 1'b1;
			end else begin
				isr_lo_next = 1'b1;
			end
		end else if (cpu_reti) begin
			if (isr_hi_reg) begin
				isr_hi_next = 1'b0;
			end else begin
				isr_lo_next = 1'b0;
			end
		end
		unique case (hold_reg)
			ST_RUN: begin
				if (cpu_reti) begin
					hold_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cpu_instr_done && !cpu_reti) begin
					hold_next = ST_RUN;
				end
			end
		endcase
		// A running routine blocks its own level and any below
		can_hi = |hi_vec && !isr_hi_reg && hold_reg == ST_RUN;
		can_lo = |lo_vec && !isr_hi_reg && !isr_lo_reg &&
			hold_reg == ST_RUN;
		req_next.req = (can_hi || can_lo) && !(cpu_irq_ack && req_reg.req);
		req_next.high = can_hi;
		req_next.vec = can_hi ? first_set(hi_vec) : first_set(lo_vec);
		if (!req_next.req) begin
			req_next.high = 1'b0;
			req_next.vec = 4'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pend_reg <= '0;
			isr_hi_reg <= 1'b0;
			isr_lo_reg <= 1'b0;
			hold_reg <= ST_RUN;
			req_reg <= '0;
		end else begin
			pend_reg <= pend_next;
			isr_hi_reg <= isr_hi_next;
			isr_lo_reg <= isr_lo_next;
			hold_reg <= hold_next;
			req_reg <= req_next;
		end
	end

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	irqp_src_t prio_d_reg;
	always_ff @(posedge clk) begin
		prio_d_reg <= prio_vec;
	end

	bit7_reads_one_a: assert property (
		ahb_go && !hwrite && sel_a == REG_BASE_PRIO |=> hrdata[7])
		else $error("basic priority bit 7 read as zero");

	prio_level_map_a: assert property (
		cpu_irq.req |-> cpu_irq.high == prio_d_reg[cpu_irq.vec])
		else $error("request level differs from its priority bit");

	enable_gating_a: assert property (
		pend_reg[`IRQP_SRC_PCA] == $past(counter_array_flag &&
		global_irq_enable && ext_irq_enable_1_reg[`IRQP_EXT_PCA]) &&
		pend_reg[`IRQP_SRC_CONV] == $past(conversion_complete_flag &&
		global_irq_enable && ext_irq_enable_1_reg[`IRQP_EXT_CONV]))
		else $error("pending vector not gated by enables");

	timer3_either_a: assert property (
		timer3_high_overflow_flag && global_irq_enable &&
		ext_irq_enable_1_reg[`IRQP_EXT_T3] |=> pend_reg[`IRQP_SRC_T3])
		else $error("timer 3 high flag did not pend");

	rsvd_read_zero_a: assert property (
		ahb_go && !hwrite && (sel_a == REG_EXT_EN ||
		sel_a == REG_EXT_PRIO) |=> !hrdata[6] && !hrdata[1])
		else $error("reserved bit read as one");

	global_off_a: assert property (
		!global_irq_enable ##1 !global_irq_enable |=> !cpu_irq.req)
		else $error("request while globally disabled");

	high_isr_block_a: assert property (
		isr_hi_reg |=> !cpu_irq.req)
		else $error("request during high level routine");

	reti_hold_a: assert property (
		cpu_reti |=> hold_reg == ST_HOLD ##0 !cpu_irq.req[*1] ##1
		!cpu_irq.req)
		else $error("request too soon after return");

	low_nest_a: assert property (
		isr_lo_reg && !isr_hi_reg && hold_reg == ST_RUN |=>
		!cpu_irq.req || cpu_irq.high)
		else $error("low request nested into low routine");

	smbus_gate_a: assert property (
		!ext_irq_enable_1_reg[`IRQP_EXT_SMB] |=> !pend_reg[`IRQP_SRC_SMB])
		else $error("SMBus request passed while masked");

	window_gate_a: assert property (
		!ext_irq_enable_1_reg[`IRQP_EXT_WCMP] |=>
		!pend_reg[`IRQP_SRC_WCMP])
		else $error("window compare request passed while masked");

	cmp_either_a: assert property (
		comparator_falling_flag && global_irq_enable &&
		ext_irq_enable_1_reg[`IRQP_EXT_CMP] |=> pend_reg[`IRQP_SRC_CMP])
		else $error("comparator falling flag did not pend");

	ack_drop_a: assert property (
		cpu_irq_ack && cpu_irq.req |=> !cpu_irq.req)
		else $error("request stood after it was taken");

	high_req_c: cover property (cpu_irq.req && cpu_irq.high);
	nest_c: cover property (isr_lo_reg ##1 cpu_irq.req && cpu_irq.high);
	reti_c: cover property (cpu_reti ##[1:20] cpu_irq.req);
	hold_c: cover property (hold_reg == ST_HOLD ##1 hold_reg == ST_RUN);

endmodule

// *** verification/irqp_cpu_model.sv ***
/*
 * Model of the CPU core side: takes a standing request after a
 * programmable number of cycles. Assumes irqp_pkg compiled first.
 */
`timescale 1ns/100ps

module irqp_cpu_model import irqp_pkg::*; #(
	parameter int DELAY = 3
) (
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// Request side
	input wire irqp_req_t cpu_irq,
	input wire logic auto_ack,
	output logic cpu_irq_ack
);
	int wait_cnt;

	// Ack only while a request stands, one cycle wide
	always_ff @(posedge clk) begin
		if (sys_rst || !cpu_irq.req || cpu_irq_ack) begin
			wait_cnt <= 0;
			cpu_irq_ack <= 1'b0;
		end else if (auto_ack && wait_cnt >= DELAY) begin
			cpu_irq_ack <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
endmodule

// *** verification/irq_enable_priority_regs_tb.sv ***
/*
 * Self-checking bench: registers over AHB-Lite, masks, levels, order
 * and service hold. Assumes irqp_params.svh and the CPU model.
 */
`timescale 1ns/100ps
`include "irqp_params.svh"

module irq_enable_priority_regs_tb import irqp_pkg::*; ;
	localparam logic [11:0] A_BP = 12'(`IRQP_IDX_BASE_PRIO * 4);
	localparam logic [11:0] A_EN = 12'(`IRQP_IDX_EXT_EN * 4);
	localparam logic [11:0] A_EP = 12'(`IRQP_IDX_EXT_PRIO * 4);
	localparam logic [11:0] A_CT = 12'(`IRQP_IDX_CTRL * 4);
	localparam logic [11:0] A_ST = 12'(`IRQP_IDX_STATUS * 4);
	localparam logic [11:0] A_NONE = 12'h0040;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [14:0] fl = 15'h0000;
	logic cpu_reti = 1'b0;
	logic cpu_instr_done = 1'b0;
	logic auto_ack = 1'b0;
	logic cpu_irq_ack;
	irqp_req_t cpu_irq;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	always #5 clk = ~clk;

	// Flag bit 8 is comparator falling, bit 13 timer 3 high overflow
	irqp_top irqp_top_i (
		.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.ext0_flag(fl[0]), .timer0_flag(fl[1]), .ext1_flag(fl[2]),
		.timer1_flag(fl[3]), .serial_port_flag(fl[4]),
		.timer2_flag(fl[5]), .spi_flag(fl[6]), .smbus_flag(fl[7]),
		.comparator_falling_flag(fl[8]), .window_compare_flag(fl[9]),
		.conversion_complete_flag(fl[10]), .counter_array_flag(fl[11]),
		.comparator_rising_flag(fl[12]),
		.timer3_high_overflow_flag(fl[13]),
		.timer3_low_overflow_flag(fl[14]),
		.cpu_irq_ack(cpu_irq_ack), .cpu_reti(cpu_reti),
		.cpu_instr_done(cpu_instr_done), .cpu_irq(cpu_irq)
	);

	irqp_cpu_model #(.DELAY(3)) irqp_cpu_model_i (
		.clk(clk), .sys_rst(sys_rst), .cpu_irq(cpu_irq),
		.auto_ack(auto_ack), .cpu_irq_ack(cpu_irq_ack)
	);

	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [11:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0000_0000);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0000_0000, x);
		chk(x, e);
	endtask

	task automatic t_regs();
		rdc(A_BP, 32'h0000_0080);
		rdc(A_EN, 32'h0000_0000);
		rdc(A_EP, 32'h0000_0000);
		rdc(A_CT, 32'h0000_0000);
		wr(A_BP, 32'h0000_00ff);
		wr(A_EN, 32'h0000_00bd);
		wr(A_EP, 32'h0000_00bd);
		wr(A_NONE, 32'h0000_00ff);
		rdc(A_BP, 32'h0000_00ff);
		rdc(A_EN, 32'h0000_00bd);
		rdc(A_EP, 32'h0000_00bd);
		rdc(A_NONE, 32'h0000_0000);
		wr(A_BP, 32'h0000_0000);
		rdc(A_BP, 32'h0000_0080);
		$display("test regs done");
	endtask

	// Each flag masked, then passed, at both levels
	task automatic t_src();
		int s;
		int b;
		logic [7:0] m;
		logic [5:0] ex;
		for (int i = 0; i < 15; i++) begin
			for (int p = 0; p < 2; p++) begin
				s = (i == 8) ? 12 : (i == 13) ? 14 : i;
				b = (s < 7) ? s : (s == 14) ? 7 : s - 7;
				m = 8'(1 << b);
				ex = {1'b1, p[0], 4'(s)};
				wr(A_BP, (s < 7 && p == 1) ? 32'(m) : 32'h0000_0000);
				wr(A_EP, (s >= 7 && p == 1) ? 32'(m) : 32'h0000_0000);
				wr(A_CT, 32'(s < 7 ? 8'hff & ~m : 8'hff));
				wr(A_EN, 32'(s >= 7 ? 8'hbd & ~m : 8'hbd));
				fl[i] <= 1'b1;
				repeat (3) @(posedge clk);
				chk(cpu_irq, 6'h00);
				wr(s < 7 ? A_CT : A_EN, 32'(s < 7 ? 8'hff : 8'hbd));
				repeat (3) @(posedge clk);
				if (s < 4) chk(cpu_irq, ex);
				else if (s < 7) chk(cpu_irq, ex);
				else if (s < 11) chk(cpu_irq, ex);
				else chk(cpu_irq, ex);
				fl[i] <= 1'b0;
				repeat (3) @(posedge clk);
			end
		end
		$display("test sources done");
	endtask

	task automatic t_order();
		wr(A_CT, 32'h0000_007f);
		wr(A_EP, 32'h0000_0080);
		fl <= 15'h7fff;
		repeat (3) @(posedge clk);
		chk(cpu_irq, 6'h00);
		wr(A_CT, 32'h0000_00ff);
		repeat (3) @(posedge clk);
		chk(cpu_irq, 6'h3e);
		wr(A_EP, 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk(cpu_irq, 6'h20);
		fl <= 15'h0000;
		repeat (3) @(posedge clk);
		$display("test order done");
	endtask

	// Low routine running: new low request held past return plus one
	task automatic t_hold();
		int n;
		auto_ack <= 1'b1;
		fl[6] <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cpu_irq_ack !== 1'b1 && n < 20);
		chk({31'h0, cpu_irq_ack}, 32'h0000_0001);
		auto_ack <= 1'b0;
		fl <= 15'h0001;
		repeat (4) @(posedge clk);
		chk(cpu_irq, 6'h00);
		rdc(A_ST, 32'h0000_0040);
		cpu_reti <= 1'b1;
		@(posedge clk);
		cpu_reti <= 1'b0;
		repeat (3) @(posedge clk);
		chk(cpu_irq, 6'h00);
		rdc(A_ST, 32'h0000_0020);
		cpu_instr_done <= 1'b1;
		@(posedge clk);
		cpu_instr_done <= 1'b0;
		repeat (3) @(posedge clk);
		chk(cpu_irq, 6'h20);
		fl <= 15'h0000;
		$display("test hold done");
	endtask

	// High request nests into a low routine, then blocks all levels
	task automatic t_nest();
		int n;
		wr(A_BP, 32'h0000_0002);
		fl <= 15'h0001;
		auto_ack <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cpu_irq_ack !== 1'b1 && n < 20);
		fl <= 15'h0003;
		repeat (3) @(posedge clk);
		chk(cpu_irq, 6'h31);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cpu_irq_ack !== 1'b1 && n < 20);
		chk({31'h0, cpu_irq_ack}, 32'h0000_0001);
		auto_ack <= 1'b0;
		repeat (4) @(posedge clk);
		chk(cpu_irq, 6'h00);
		rdc(A_ST, 32'h0000_00c0);
		cpu_reti <= 1'b1;
		@(posedge clk);
		cpu_reti <= 1'b0;
		cpu_instr_done <= 1'b1;
		@(posedge clk);
		cpu_instr_done <= 1'b0;
		repeat (3) @(posedge clk);
		chk(cpu_irq, 6'h31);
		fl <= 15'h0000;
		$display("test nest done");
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_src();
		t_order();
		t_hold();
		t_nest();
		conclude();
	end
endmodule
